//--- bench/pbp_src_model.sv
// partner model: playback computer or button panel driving the port inputs
// assumes the bench clock; released lines sit at their pull-up level
`timescale 1ns/1ps
module pbp_src_model (
    // clock
    input wire logic clk_i,
    // requests from the bench, active high
    input wire logic [4:0] req_i,
    input wire logic ready_i,
    // port inputs, active low
    output logic [4:0] gpi_n_o = 5'h1F
);
    ////////////////////////////////////////
    // a released line floats high, so a stale low never lingers
    always @(posedge clk_i) begin
        gpi_n_o <= ~(req_i | {ready_i, 4'h0});
    end
endmodule : pbp_src_model

//--- bench/tb_playback_and_button_port_logic.sv
// testbench: port logic against a source model, bus tasks and random buttons
// assumes pbp_pkg, pbp_port and pbp_src_model are compiled first
`timescale 1ns/1ps
module tb_playback_and_button_port_logic;
    localparam int unsigned PW = 20;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    pbp_pkg::pbp_wb_req_t wb_req = '0;
    logic [31:0] wb_dat;
    logic wb_ack;
    logic [4:0] gpi_n;
    logic [4:0] gpo_n;
    logic [4:0] btn_lamp;
    logic [4:0] btn = 5'h00;
    logic [4:0] req = 5'h00;
    logic ready = 1'b0;
    logic [31:0] pulse_q[$];
    logic [31:0] rd_q[$];
    logic [31:0] r;
    logic [31:0] mon_exp;
    logic btn_mode = 1'b0;
    int miscompares = 0;
    int total_checks = 0;
    int cnt[5];

    // short pulse width keeps the run brief
    pbp_port #(.PULSE_CYC(PW), .NPIN(5)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .wb_req_i(wb_req), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .gpi_n_i(gpi_n),
        .gpo_n_o(gpo_n), .btn_pushed_i(btn), .btn_lamp_o(btn_lamp));
    pbp_src_model SRC (.clk_i(clk_i), .req_i(req), .ready_i(ready), .gpi_n_o(gpi_n));

    ////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic chk_pin(input logic [4:0] got, input logic [4:0] exp);
        cmp({27'h0, got}, {27'h0, exp});
    endtask : chk_pin
    task automatic complete_run;
        if (miscompares == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : settle
    // one classic cycle, held until ack is seen at an edge
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        wb_req <= '0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        wb(1'b0, a, 32'h0);
    endtask : rd
    task automatic press(input logic [4:0] m, input int hold);
        @(posedge clk_i);
        req <= m;
        repeat (hold) @(posedge clk_i);
        req <= 5'h00;
    endtask : press
    function automatic logic [31:0] note(input int pin);
        return {8'(pin), 24'(PW)};
    endfunction : note

    ////////////////////////////////////////
    // monitor: each finished pulse and each read answer takes the oldest note
    always @(posedge clk_i) begin
        if (!rst_i) begin
            foreach (cnt[b]) begin
                // pins 1 and 2 are levels, not pulses; in the button profile all pins mirror buttons
                if (b == 1 || b == 2 || btn_mode) continue;
                if (gpo_n[b] === 1'b0) cnt[b]++;
                else if (cnt[b] != 0) begin
                    mon_exp = (pulse_q.size() != 0) ? pulse_q.pop_front() : 32'hFFFFFFFF;
                    cmp({8'(b), 24'(cnt[b])}, mon_exp);
                    cnt[b] = 0;
                end
            end
            if (wb_ack === 1'b1 && wb_req.we === 1'b0 && rd_q.size() != 0) begin
                cmp(wb_dat, rd_q.pop_front());
            end
        end
    end

    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        complete_run();
    end

    ////////////////////////////////////////
    initial begin
        void'($urandom(47897));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        settle(2);
        chk_pin(gpo_n, 5'h1F);
        chk_pin(btn_lamp, 5'h00);
        @(posedge clk_i);
        ready <= 1'b1;
        settle(6);
        chk_pin(gpo_n, 5'h1D);
        // held on command must act only once
        pulse_q.push_back(note(pbp_pkg::OUT_START));
        press(5'h01, 30);
        settle(6);
        chk_pin(gpo_n, 5'h1F);
        pulse_q.push_back(note(pbp_pkg::OUT_NEXT));
        press(5'h01, 3);
        settle(PW + 8);
        pulse_q.push_back(note(pbp_pkg::OUT_STOP));
        press(5'h02, 3);
        settle(PW + 8);
        chk_pin(gpo_n, 5'h1D);
        // software on and off also give start and stop pulses
        pulse_q.push_back(note(pbp_pkg::OUT_START));
        wb(1'b1, pbp_pkg::REG_CTRL, 32'h2);
        settle(PW + 8);
        rd(pbp_pkg::REG_STAT, 32'h0000_1001);
        pulse_q.push_back(note(pbp_pkg::OUT_STOP));
        wb(1'b1, pbp_pkg::REG_CTRL, 32'h4);
        settle(PW + 8);
        press(5'h04, 3);
        settle(6);
        chk_pin(gpo_n, 5'h19);
        wb(1'b1, pbp_pkg::REG_CTRL, 32'h8);
        settle(3);
        chk_pin(gpo_n, 5'h1D);
        // unmapped place ignores writes and reads zero
        r = $urandom;
        wb(1'b1, 8'h08, r);
        rd(8'h08, 32'h0);
        rd(pbp_pkg::REG_CTRL, 32'h0);
        wb(1'b1, pbp_pkg::REG_CTRL, 32'h1);
        btn_mode = 1'b1;
        rd(pbp_pkg::REG_CTRL, 32'h1);
        // button profile: pin commands must give no pulses
        repeat (6) begin
            r = $urandom;
            @(posedge clk_i);
            btn <= r[4:0];
            req <= r[9:5];
            ready <= 1'b0;
            settle(6);
            chk_pin(gpo_n, ~btn);
            chk_pin(btn_lamp, req);
        end
        // channel must stay off and no timer run after random pin commands
        rd(pbp_pkg::REG_STAT, {11'h000, btn, 3'h0, req, 5'h00, btn[1], 2'h0});
        settle(PW + 4);
        cmp(32'(pulse_q.size()), 32'h0);
        complete_run();
    end
endmodule : tb_playback_and_button_port_logic

//--- hdl/pbp_pkg.sv
// package for the playback and button port: timing, pin map, register map, types
// assumes one 100 MHz system clock and a classic wishbone register bus
package pbp_pkg;
    // pulse timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned PULSE_MS = 100;
    localparam int unsigned PULSE_CYC_DEF = PULSE_MS * (CLK_HZ / 1000);
    localparam int unsigned PULSE_CW = 24;
    // command pin positions (pins 11..15, active low)
    localparam int IN_ON = 0;
    localparam int IN_OFF = 1;
    localparam int IN_PREV = 2;
    localparam int IN_READY = 4;
    // output pin positions (pins 1..5, active low)
    localparam int OUT_NEXT = 0;
    localparam int OUT_IDLE = 1;
    localparam int OUT_PREV = 2;
    localparam int OUT_START = 3;
    localparam int OUT_STOP = 4;
    // pulse timer slots
    localparam int PI_START = 0;
    localparam int PI_STOP = 1;
    localparam int PI_NEXT = 2;
    localparam int NPULSE = 3;
    // register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam int CTRL_PROF = 0;
    localparam int CTRL_SW_ON = 1;
    localparam int CTRL_SW_OFF = 2;
    localparam int CTRL_PREV_CLR = 3;
    localparam logic CTRL_PROF_RST = 1'b0;
    localparam int STAT_IN_LSB = 8;
    localparam int STAT_OUT_LSB = 16;
    // channel state
    typedef enum logic {PBP_CH_OFF = 1'b0, PBP_CH_ON = 1'b1} pbp_ch_t;
    // wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } pbp_wb_req_t;
endpackage : pbp_pkg

//--- hdl/pbp_port.sv
// logic behind one general-purpose control port: playback profile and user button profile
// assumes inputs synchronous to clk_i, pins active low, wishbone classic master
`timescale 1ns/1ps

// Summary of operation
// - channel off plus on command: switch on, one 100 ms start pulse
// - on command while on: 100 ms advance pulse, none on first switch-on
// - off command while on switches channel off and triggers 100 ms stop pulse
// - every on-to-off transition reloads the 100 ms stop timer; the stop pin pulses only in the playback profile
// - playback profile: idle-ready output active only while channel off and source ready asserted
// - audition request turns audition on; its indicator follows audition state
// - button profile: each lamp input lights its button lamp while asserted
// - button profile: each switch output active while its button held, one clock later
module pbp_port #(
    parameter int unsigned PULSE_CYC = pbp_pkg::PULSE_CYC_DEF,
    parameter int unsigned NPIN = 5
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire pbp_pkg::pbp_wb_req_t wb_req_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // port pins, active low
    input wire logic [NPIN-1:0] gpi_n_i,
    output logic [NPIN-1:0] gpo_n_o,
    // console user buttons
    input wire logic [NPIN-1:0] btn_pushed_i,
    output logic [NPIN-1:0] btn_lamp_o
);
    localparam logic [pbp_pkg::PULSE_CW-1:0] PLEN = pbp_pkg::PULSE_CW'(PULSE_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // input synchroniser and edge detect
    logic [NPIN-1:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
    logic [NPIN-1:0] in_a, fell;

    // first stage is read only by the second
    always_comb begin
        s1_d = gpi_n_i;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    // a held-low pin gives a single edge, so one action per press
    assign in_a = ~s2_q;
    assign fell = ~s2_q & s3_q;

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave: ack one cycle after request, write at the acked edge
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic prof_q, prof_d;
    logic sw_on_q, sw_on_d, sw_off_q, sw_off_d, sw_pclr_q, sw_pclr_d;
    logic wr_ctrl;
    logic [31:0] stat_w;
    pbp_pkg::pbp_ch_t ch_q, ch_d;
    logic prev_q, prev_d;
    logic [pbp_pkg::PULSE_CW-1:0] cnt_q [pbp_pkg::NPULSE];
    logic [pbp_pkg::NPULSE-1:0] act;

    assign wr_ctrl = ack_q && wb_req_i.cyc && wb_req_i.stb && wb_req_i.we
        && wb_req_i.sel[0] && wb_req_i.adr == pbp_pkg::REG_CTRL;

    // status word shows channel state, timers, pin levels
    always_comb begin
        stat_w = '0;
        stat_w[0] = (ch_q == pbp_pkg::PBP_CH_ON);
        stat_w[1] = prev_q;
        stat_w[2] = ~gpo_n_o[pbp_pkg::OUT_IDLE];
        stat_w[5:3] = act;
        stat_w[pbp_pkg::STAT_IN_LSB +: NPIN] = in_a;
        stat_w[pbp_pkg::STAT_OUT_LSB +: NPIN] = ~gpo_n_o;
    end

    // unmapped addresses still ack and read zero
    always_comb begin
        ack_d = wb_req_i.cyc && wb_req_i.stb && !ack_q;
        rdat_d = '0;
        if (ack_d && !wb_req_i.we) begin
            case (wb_req_i.adr)
                pbp_pkg::REG_CTRL: rdat_d = {31'h0000_0000, prof_q};
                pbp_pkg::REG_STAT: rdat_d = stat_w;
                default: rdat_d = '0;
            endcase
        end
        prof_d = wr_ctrl ? wb_req_i.dat[pbp_pkg::CTRL_PROF] : prof_q;
        sw_on_d = wr_ctrl && wb_req_i.dat[pbp_pkg::CTRL_SW_ON];
        sw_off_d = wr_ctrl && wb_req_i.dat[pbp_pkg::CTRL_SW_OFF];
        sw_pclr_d = wr_ctrl && wb_req_i.dat[pbp_pkg::CTRL_PREV_CLR];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= '0;
            prof_q <= pbp_pkg::CTRL_PROF_RST;
            sw_on_q <= 1'b0;
            sw_off_q <= 1'b0;
            sw_pclr_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            prof_q <= prof_d;
            sw_on_q <= sw_on_d;
            sw_off_q <= sw_off_d;
            sw_pclr_q <= sw_pclr_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    ////////////////////////////////////////////////////////////////////////////
    // channel state, audition state
    logic on_evt, off_evt, prev_evt, ready_a;

    // pin commands only count in the playback profile; software commands always
    assign on_evt = (!prof_q && fell[pbp_pkg::IN_ON]) || sw_on_q;
    assign off_evt = (!prof_q && fell[pbp_pkg::IN_OFF]) || sw_off_q;
    assign prev_evt = !prof_q && fell[pbp_pkg::IN_PREV];
    assign ready_a = in_a[pbp_pkg::IN_READY];

    // off beats on in the same cycle: stopping is the safe outcome
    always_comb begin
        ch_d = ch_q;
        case (ch_q)
            pbp_pkg::PBP_CH_OFF: if (on_evt && !off_evt) ch_d = pbp_pkg::PBP_CH_ON;
            pbp_pkg::PBP_CH_ON: if (off_evt) ch_d = pbp_pkg::PBP_CH_OFF;
            default: ch_d = pbp_pkg::PBP_CH_OFF;
        endcase
        // request sets, software clears; set wins
        prev_d = prev_evt ? 1'b1 : (sw_pclr_q ? 1'b0 : prev_q);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ch_q <= pbp_pkg::PBP_CH_OFF;
            prev_q <= 1'b0;
        end else begin
            ch_q <= ch_d;
            prev_q <= prev_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pulse timers; a new trigger restarts the full width
    logic [pbp_pkg::NPULSE-1:0] trig;

    always_comb begin
        trig[pbp_pkg::PI_START] = ch_q == pbp_pkg::PBP_CH_OFF && ch_d == pbp_pkg::PBP_CH_ON;
        trig[pbp_pkg::PI_STOP] = ch_q == pbp_pkg::PBP_CH_ON && ch_d == pbp_pkg::PBP_CH_OFF;
        trig[pbp_pkg::PI_NEXT] = ch_q == pbp_pkg::PBP_CH_ON && on_evt && !off_evt;
    end

    for (genvar g = 0; g < pbp_pkg::NPULSE; g++) begin : g_pulse
        logic [pbp_pkg::PULSE_CW-1:0] cnt_d;

        always_comb begin
            cnt_d = cnt_q[g];
            if (trig[g]) cnt_d = PLEN;
            else if (cnt_q[g] != '0) cnt_d = cnt_q[g] - 1'b1;
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) cnt_q[g] <= '0;
            else cnt_q[g] <= cnt_d;
        end
    end

    // busy flags; one process so the flag vector has a single driver
    always_comb begin
        for (int i = 0; i < pbp_pkg::NPULSE; i++) begin
            act[i] = cnt_q[i] != '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output pins and lamps, all from flip-flops
    logic [NPIN-1:0] gpo_n_q, gpo_n_d, lamp_q, lamp_d;

    always_comb begin
        gpo_n_d = '1;
        lamp_d = '0;
        if (prof_q) begin
            gpo_n_d = ~btn_pushed_i;
            lamp_d = in_a;
        end else begin
            gpo_n_d[pbp_pkg::OUT_NEXT] = ~act[pbp_pkg::PI_NEXT];
            gpo_n_d[pbp_pkg::OUT_IDLE] = ~(ch_q == pbp_pkg::PBP_CH_OFF && ready_a);
            gpo_n_d[pbp_pkg::OUT_PREV] = ~prev_q;
            gpo_n_d[pbp_pkg::OUT_START] = ~act[pbp_pkg::PI_START];
            gpo_n_d[pbp_pkg::OUT_STOP] = ~act[pbp_pkg::PI_STOP];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gpo_n_q <= '1;
            lamp_q <= '0;
        end else begin
            gpo_n_q <= gpo_n_d;
            lamp_q <= lamp_d;
        end
    end

    assign gpo_n_o = gpo_n_q;
    assign btn_lamp_o = lamp_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // length of the current start pulse as seen on the pin
    logic [pbp_pkg::PULSE_CW-1:0] run_q, run_d;
    always_comb begin
        run_d = gpo_n_q[pbp_pkg::OUT_START] ? '0 : run_q + 1'b1;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) run_q <= '0;
        else run_q <= run_d;
    end

    sequence s_switch_on;
        ch_q == pbp_pkg::PBP_CH_ON && cnt_q[pbp_pkg::PI_START] == PLEN;
    endsequence

    sequence s_start_pin;
        !gpo_n_q[pbp_pkg::OUT_START] && gpo_n_q[pbp_pkg::OUT_NEXT];
    endsequence

    property p_on_start;
        ch_q == pbp_pkg::PBP_CH_OFF && on_evt && !off_evt && !prof_q
            |=> s_switch_on ##1 s_start_pin;
    endproperty
    a_on_start: assert property (p_on_start) else $error("on command gave no start");

    property p_next;
        ch_q == pbp_pkg::PBP_CH_ON && on_evt && !off_evt
            |=> cnt_q[pbp_pkg::PI_NEXT] == PLEN ##1 !gpo_n_q[pbp_pkg::OUT_NEXT] || prof_q;
    endproperty
    a_next: assert property (p_next) else $error("repeat on gave no advance pulse");

    property p_off;
        off_evt |=> ch_q == pbp_pkg::PBP_CH_OFF;
    endproperty
    a_off: assert property (p_off) else $error("off command left channel on");

    property p_stop;
        $fell(ch_q) |-> cnt_q[pbp_pkg::PI_STOP] == PLEN;
    endproperty
    a_stop: assert property (p_stop) else $error("channel off without stop pulse");

    // the loaded stop timer must reach the pin one cycle later
    property p_stop_pin;
        $fell(ch_q) && !prof_q |=> !gpo_n_q[pbp_pkg::OUT_STOP];
    endproperty
    a_stop_pin: assert property (p_stop_pin) else $error("stop pin not driven");

    property p_idle;
        !prof_q |=> gpo_n_q[pbp_pkg::OUT_IDLE]
            == $past(!(ch_q == pbp_pkg::PBP_CH_OFF && ready_a));
    endproperty
    a_idle: assert property (p_idle) else $error("idle-ready pin wrong");

    property p_prev;
        prev_evt |=> prev_q ##1 !gpo_n_q[pbp_pkg::OUT_PREV] || prof_q;
    endproperty
    a_prev: assert property (p_prev) else $error("audition not shown");

    property p_lamp;
        prof_q |=> btn_lamp_o == $past(in_a);
    endproperty
    a_lamp: assert property (p_lamp) else $error("button lamp does not follow input");

    property p_switch;
        prof_q |=> gpo_n_o == $past(~btn_pushed_i);
    endproperty
    a_switch: assert property (p_switch) else $error("switch pin does not follow button");

    property p_once;
        fell[pbp_pkg::IN_ON] |=> !fell[pbp_pkg::IN_ON];
    endproperty
    a_once: assert property (p_once) else $error("held input acted twice");

    property p_len;
        $rose(gpo_n_q[pbp_pkg::OUT_START]) && !prof_q |-> run_q >= PLEN;
    endproperty
    a_len: assert property (p_len) else $error("start pulse too short");

endmodule : pbp_port
